// [rtl/ext_bus_pkg.sv]
package ext_bus_pkg;

  // ----------------------------------------------------------------
  // Register map: printed offsets are indices, byte address is 4x
  // ----------------------------------------------------------------
  localparam int unsigned APB_ADDR_W = 12;
  localparam logic [7:0] MODE_IDX = 8'hEB;
  localparam logic [7:0] STALL_IDX = 8'hF6;
  localparam logic [7:0] WAIT_IDX = 8'hFC;
  localparam logic [7:0] STATUS_IDX = 8'hE0;
  localparam logic [7:0] PINCFG_IDX = 8'hE1;
  localparam logic [11:0] MODE_ADDR = {2'h0, MODE_IDX, 2'h0};
  localparam logic [11:0] STALL_ADDR = {2'h0, STALL_IDX, 2'h0};
  localparam logic [11:0] WAIT_ADDR = {2'h0, WAIT_IDX, 2'h0};
  localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};
  localparam logic [11:0] PINCFG_ADDR = {2'h0, PINCFG_IDX, 2'h0};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'hE0;
  localparam logic [7:0] STALL_RST = 8'h02;
  localparam logic [7:0] WAIT_RST = 8'h7F;
  localparam logic [7:0] PINCFG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FLOAT_BIT = 0;
  localparam int unsigned BUS_REQUEST_N_EN_BIT = 1;
  localparam int unsigned STALL_EN_BIT = 0;
  localparam int unsigned DWAIT_LSB = 0;
  localparam int unsigned PWAIT_LSB = 3;
  localparam int unsigned PD_EN_BIT = 0;

  // ----------------------------------------------------------------
  // Cycle counts (one clock is one crystal / peripheral clock period)
  // ----------------------------------------------------------------
  localparam int unsigned CRYSTAL_DIV = 32;
  localparam int unsigned SYNC_MIN_PERIODS = 32 * 31;
  localparam logic [1:0] RESUME_CLKS = 2'h2;
  localparam logic [4:0] SYNC_PHASE_LOAD = 5'h04;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET  = 4'b0000,
    ST_IDLE   = 4'b0001,
    ST_T1A    = 4'b0010,
    ST_T1B    = 4'b0011,
    ST_T2A    = 4'b0100,
    ST_T2B    = 4'b0101,
    ST_WAIT   = 4'b0110,
    ST_T3A    = 4'b0111,
    ST_T3B    = 4'b1000,
    ST_FLOAT  = 4'b1001,
    ST_RESUME = 4'b1010
  } bus_state_type;

  typedef struct packed {
    logic write;
    logic prog;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_type;

endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE_VAL = '1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] ff1_r;
  logic [WIDTH-1:0] ff2_r;
  logic [WIDTH-1:0] ff3_r;

  // Three stages; a change counts only once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ff1_r <= IDLE_VAL;
      ff2_r <= IDLE_VAL;
      ff3_r <= IDLE_VAL;
      level_o <= IDLE_VAL;
    end else begin
      ff1_r <= pin_i;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      for (int i = 0; i < WIDTH; i++) begin
        if (ff2_r[i] == ff3_r[i]) begin
          level_o[i] <= ff3_r[i];
        end
      end
    end
  end

endmodule

// [rtl/ext_mem_if.sv]
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// RL1 - In reset, a slave aligns its clock phase to pulses on its read/write pin.
// RL2 - Reset held at least 992 crystal periods; all parts share one clock.
// RL3 - In reset, read/write pin is an input with weak pull-up.
// RL4 - Decide on-chip or off-chip per address; only off-chip pulses data strobe.
// RL5 - Address, read/write and program/data valid at address strobe rising edge.
// RL6 - Float strobes and read/write during bus grant or when float bit set.
// RL7 - Data strobe stays high for whole on-chip memory cycle.
// RL8 - Write data valid while data strobe low; read data valid before it rises.
// RL9 - Read/write is 1 for read, 0 for write, held until next cycle.
// RL10 - Program/data select 1 program, 0 data; output enabled by software.
// RL11 - Stall input honoured only when stall enable bit set; lengthens cycle.
// RL12 - Bus request input honoured only when bus request enable set.
// RL13 - Bus grant output low while bus is given up.
// RL14 - Muxed port carries low address/data, high port A8-A15, extra port low address.
// RL15 - Cycle is phases one to three; address out at strobe fall, held to next.
// RL16 - Read: muxed port floats from data strobe fall to next address strobe fall.
// RL17 - Write: muxed port driven, data from phase two until next address.
// RL18 - Read strobe low from phase two start; write from mid two to mid three.
// RL19 - On-chip accesses get no waits; waits from stall pin or wait generator.
// RL20 - Stall sampled in phase two; each low sample adds one clock and resamples.
// RL21 - Program and data waits set independently, 0 to 7, data in bits 2..0.
// RL22 - Wait count N adds exactly N clocks; both counts reset to 7.
// RL23 - In reset, data strobe low and address strobe toggles at crystal/32.
// RL24 - Bus request sampled in phase three; if low, stall and float, grant low.
// RL25 - When request goes high, drive pins again, wait two clocks, then resume.
module ext_mem_if #(
  parameter logic [15:0] ONCHIP_PROG_LIMIT = 16'h4000,
  parameter logic [15:0] ONCHIP_DATA_LIMIT = 16'h0800
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic CHIP_RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ext_bus_pkg::APB_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic REQ_VALID_I,
  input wire ext_bus_pkg::mem_req_type REQ_I,
  output logic REQ_READY_O,
  output logic DONE_O,
  output logic [7:0] RDATA_O,
  output logic ADDRESS_STROBE_N_O,
  output logic ADDRESS_STROBE_OE_O,
  output logic DATA_STROBE_N_O,
  output logic DATA_STROBE_OE_O,
  input wire logic READ_NOT_WRITE_I,
  output logic READ_NOT_WRITE_O,
  output logic READ_NOT_WRITE_OE_O,
  output logic READ_NOT_WRITE_PULLUP_O,
  output logic PROGRAM_DATA_SELECT_O,
  output logic PROGRAM_DATA_SELECT_OE_O,
  input wire logic [7:0] MUXED_ADDR_DATA_PORT_I,
  output logic [7:0] MUXED_ADDR_DATA_PORT_O,
  output logic MUXED_ADDR_DATA_PORT_OE_O,
  output logic [7:0] HIGH_ADDRESS_PORT_O,
  output logic HIGH_ADDRESS_PORT_OE_O,
  output logic [7:0] EXTRA_LOW_ADDRESS_PORT_O,
  output logic EXTRA_LOW_ADDRESS_PORT_OE_O,
  input wire logic SLOW_MEMORY_HOLD_N_I,
  input wire logic BUS_REQUEST_N_I,
  output logic BUS_GRANT_N_O
);
  import ext_bus_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bus_state_type state_r;
  bus_state_type state_nxt;
  mem_req_type req_r;
  mem_req_type req_cur;
  logic [7:0] mode_r;
  logic [7:0] stall_cfg_r;
  logic [7:0] wait_cfg_r;
  logic [7:0] pincfg_r;
  logic [2:0] wait_cnt_r;
  logic [2:0] wait_n;
  logic [1:0] resume_cnt_r;
  logic [4:0] div_r;
  logic ext_r;
  logic ext_cur;
  logic take;
  logic chip_run;
  logic stall_low;
  logic bus_request_n_low;
  logic rw_in;
  logic rw_in_d_r;
  logic stall_act;
  logic bus_request_n_act;
  logic flt_nxt;
  logic drive_r;
  logic drive_nxt;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [2:0] wait_seen_r;
  logic [3:0] in_sync;

  // Asynchronous pins pass the three-stage synchroniser; the reset pin
  // starts out as in reset, so no cycle can start before it is seen high
  pin_sync #(
    .WIDTH(4),
    .IDLE_VAL(4'h7)
  ) u_pin_sync (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i({CHIP_RESET_N_I, SLOW_MEMORY_HOLD_N_I, BUS_REQUEST_N_I, READ_NOT_WRITE_I}),
    .level_o(in_sync)
  );
  assign rw_in = in_sync[0];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign chip_run = in_sync[3];
  assign stall_low = !in_sync[2];
  assign bus_request_n_low = !in_sync[1];
  // Stall and bus request ignored unless software enabled them
  assign stall_act = stall_cfg_r[STALL_EN_BIT] && stall_low; // RL11
  assign bus_request_n_act = mode_r[BUS_REQUEST_N_EN_BIT] && bus_request_n_low; // RL12
  assign take = REQ_READY_O && REQ_VALID_I;
  assign req_cur = take ? REQ_I : req_r;
  // On-chip map: program below its limit, data below its limit
  assign ext_cur = REQ_I.prog ? (REQ_I.addr >= ONCHIP_PROG_LIMIT) :
                   (REQ_I.addr >= ONCHIP_DATA_LIMIT); // RL4
  assign wait_n = req_r.prog ? wait_cfg_r[PWAIT_LSB +: 3] : wait_cfg_r[DWAIT_LSB +: 3]; // RL21

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  // Each phase is two clocks, so strobes can move at mid-phase
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET: state_nxt = ST_IDLE;
      ST_IDLE: begin
        if (REQ_VALID_I) begin
          state_nxt = ST_T1A; // RL15
        end
      end
      ST_T1A: state_nxt = ST_T1B;
      ST_T1B: state_nxt = ST_T2A;
      ST_T2A: state_nxt = ST_T2B;
      ST_T2B: begin
        // On-chip cycles never stretch
        if (ext_r && (wait_n != 3'h0 || stall_act)) begin
          state_nxt = ST_WAIT; // RL19 RL20
        end else begin
          state_nxt = ST_T3A;
        end
      end
      ST_WAIT: begin
        // Counted waits first, then one extra clock per low stall sample
        if (wait_cnt_r <= 3'h1 && !stall_act) begin
          state_nxt = ST_T3A; // RL22 RL20
        end
      end
      ST_T3A: state_nxt = ST_T3B;
      ST_T3B: begin
        if (bus_request_n_act) begin
          state_nxt = ST_FLOAT; // RL24
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_FLOAT: begin
        if (!bus_request_n_act) begin
          state_nxt = ST_RESUME; // RL25
        end
      end
      ST_RESUME: begin
        if (resume_cnt_r == RESUME_CLKS - 2'h1) begin
          state_nxt = ST_IDLE; // RL25
        end
      end
      default: state_nxt = ST_RESET;
    endcase
    if (!chip_run) begin
      state_nxt = ST_RESET;
    end
  end

  // State and request capture
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= ST_RESET;
      req_r <= '0;
      ext_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        req_r <= REQ_I;
        ext_r <= ext_cur;
      end
    end
  end

  // Wait, resume and reset-divider counters
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wait_cnt_r <= 3'h0;
      resume_cnt_r <= 2'h0;
      div_r <= 5'h00;
      rw_in_d_r <= 1'b1;
    end else begin
      if (state_r == ST_T2B) begin
        wait_cnt_r <= wait_n;
      end else if (state_r == ST_WAIT && wait_cnt_r != 3'h0) begin
        wait_cnt_r <= wait_cnt_r - 3'h1;
      end
      resume_cnt_r <= (state_r == ST_RESUME) ? resume_cnt_r + 2'h1 : 2'h0;
      // Edge detect uses the sampled pin; phase only matters while in reset
      rw_in_d_r <= rw_in;
      if (state_r == ST_RESET && rw_in && !rw_in_d_r) begin
        div_r <= SYNC_PHASE_LOAD; // RL1
      end else begin
        div_r <= div_r + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, all registered; all but the program/data select enable from the next state
  // ----------------------------------------------------------------
  // Bus is floated by software or while granted away
  assign flt_nxt = mode_r[FLOAT_BIT] || state_nxt == ST_FLOAT; // RL6
  // Muxed port: driven for address, stays driven for write data,
  // released for read data until the next address phase
  always_comb begin
    drive_nxt = drive_r;
    if (state_nxt == ST_T1A) begin
      drive_nxt = 1'b1; // RL15
    end else if (state_nxt == ST_T2A) begin
      drive_nxt = req_cur.write; // RL16 RL17
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      drive_r <= 1'b0;
      ADDRESS_STROBE_N_O <= 1'b1;
      ADDRESS_STROBE_OE_O <= 1'b0;
      DATA_STROBE_N_O <= 1'b0;
      DATA_STROBE_OE_O <= 1'b0;
      READ_NOT_WRITE_OE_O <= 1'b0;
      READ_NOT_WRITE_PULLUP_O <= 1'b1;
      MUXED_ADDR_DATA_PORT_OE_O <= 1'b0;
      HIGH_ADDRESS_PORT_OE_O <= 1'b0;
      EXTRA_LOW_ADDRESS_PORT_OE_O <= 1'b0;
      BUS_GRANT_N_O <= 1'b1;
    end else if (state_nxt == ST_RESET) begin
      drive_r <= 1'b0;
      ADDRESS_STROBE_N_O <= div_r[4]; // RL23
      ADDRESS_STROBE_OE_O <= 1'b1;
      DATA_STROBE_N_O <= 1'b0; // RL23
      DATA_STROBE_OE_O <= 1'b1;
      READ_NOT_WRITE_OE_O <= 1'b0; // RL3
      READ_NOT_WRITE_PULLUP_O <= 1'b1; // RL3
      MUXED_ADDR_DATA_PORT_OE_O <= 1'b0;
      HIGH_ADDRESS_PORT_OE_O <= 1'b0;
      EXTRA_LOW_ADDRESS_PORT_OE_O <= 1'b0;
      BUS_GRANT_N_O <= 1'b1;
    end else begin
      drive_r <= drive_nxt;
      ADDRESS_STROBE_N_O <= state_nxt != ST_T1A; // RL5 RL15
      ADDRESS_STROBE_OE_O <= !flt_nxt; // RL6
      // Read strobe spans phase two to end of three; write strobe mid to mid
      if (req_cur.write) begin
        DATA_STROBE_N_O <= !(ext_cur && take ? 1'b0 : ext_r &&
          (state_nxt == ST_T2B || state_nxt == ST_WAIT || state_nxt == ST_T3A)); // RL18
      end else begin
        DATA_STROBE_N_O <= !(ext_r && state_nxt >= ST_T2A && state_nxt <= ST_T3B); // RL18 RL7
      end
      DATA_STROBE_OE_O <= !flt_nxt; // RL6
      READ_NOT_WRITE_OE_O <= !flt_nxt; // RL6
      READ_NOT_WRITE_PULLUP_O <= 1'b0;
      MUXED_ADDR_DATA_PORT_OE_O <= !flt_nxt && drive_nxt; // RL16 RL17
      HIGH_ADDRESS_PORT_OE_O <= !flt_nxt; // RL14
      EXTRA_LOW_ADDRESS_PORT_OE_O <= !flt_nxt; // RL14
      BUS_GRANT_N_O <= state_nxt != ST_FLOAT; // RL13
    end
  end

  // Address, direction and space set at cycle start and held to the next
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      READ_NOT_WRITE_O <= 1'b1;
      PROGRAM_DATA_SELECT_O <= 1'b1;
      PROGRAM_DATA_SELECT_OE_O <= 1'b0;
      MUXED_ADDR_DATA_PORT_O <= 8'h00;
      HIGH_ADDRESS_PORT_O <= 8'h00;
      EXTRA_LOW_ADDRESS_PORT_O <= 8'h00;
    end else begin
      PROGRAM_DATA_SELECT_OE_O <= pincfg_r[PD_EN_BIT] && chip_run; // RL10
      if (state_nxt == ST_T1A) begin
        READ_NOT_WRITE_O <= !req_cur.write; // RL9
        PROGRAM_DATA_SELECT_O <= req_cur.prog; // RL10
        MUXED_ADDR_DATA_PORT_O <= req_cur.addr[7:0]; // RL14
        HIGH_ADDRESS_PORT_O <= req_cur.addr[15:8]; // RL14 RL15
        EXTRA_LOW_ADDRESS_PORT_O <= req_cur.addr[7:0]; // RL14 RL15
      end else if (state_nxt == ST_T2A && req_cur.write) begin
        MUXED_ADDR_DATA_PORT_O <= req_cur.wdata; // RL8 RL17
      end
    end
  end

  // Core side: read data taken in the last clock before strobe rises
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REQ_READY_O <= 1'b0;
      DONE_O <= 1'b0;
      RDATA_O <= 8'h00;
    end else begin
      REQ_READY_O <= state_nxt == ST_IDLE && !take;
      DONE_O <= state_r == ST_T3B;
      if (state_r == ST_T3B && !req_r.write) begin
        RDATA_O <= ext_r ? MUXED_ADDR_DATA_PORT_I : 8'h00; // RL8
      end
    end
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (PADDR_I)
      MODE_ADDR: rd_mux = {24'h00_0000, mode_r};
      STALL_ADDR: rd_mux = {24'h00_0000, stall_cfg_r};
      WAIT_ADDR: rd_mux = {24'h00_0000, wait_cfg_r};
      PINCFG_ADDR: rd_mux = {24'h00_0000, pincfg_r};
      STATUS_ADDR: rd_mux = {24'h00_0000, !BUS_GRANT_N_O, !chip_run, 2'h0, state_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // Slave answers in the first access cycle; unmapped gets an error
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I && !PENABLE_I;
      if (PSEL_I && !PENABLE_I) begin
        PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_mux;
        PSLVERR_O <= !rd_hit;
      end
    end
  end

  // Writes take effect at the completing access edge only
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mode_r <= MODE_RST;
      stall_cfg_r <= STALL_RST;
      wait_cfg_r <= WAIT_RST; // RL22
      pincfg_r <= PINCFG_RST;
    end else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I) begin
      unique case (PADDR_I)
        MODE_ADDR: mode_r <= PWDATA_I[7:0];
        STALL_ADDR: stall_cfg_r <= PWDATA_I[7:0];
        WAIT_ADDR: wait_cfg_r <= PWDATA_I[7:0]; // RL21
        PINCFG_ADDR: pincfg_r <= PWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dflt_cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Helper: clocks spent in the wait state of the current cycle
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wait_seen_r <= 3'h0;
    end else if (state_r == ST_T2B) begin
      wait_seen_r <= 3'h0;
    end else if (state_r == ST_WAIT) begin
      wait_seen_r <= wait_seen_r + 3'h1;
    end
  end

  sequence resume_seq;
    state_r == ST_RESUME [*2] ##1 state_r == ST_IDLE;
  endsequence

  internal_ds_high_a: assert property (!ext_r && state_r >= ST_T1A && state_r <= ST_T3B
    |-> DATA_STROBE_N_O) else $error("strobe pulsed on on-chip cycle"); // RL7
  rw_level_a: assert property (state_r == ST_T1B |-> READ_NOT_WRITE_O == !req_r.write
    && HIGH_ADDRESS_PORT_O == req_r.addr[15:8]) else $error("address or direction wrong"); // RL5
  float_ctl_a: assert property (mode_r[FLOAT_BIT] && state_r != ST_RESET
    |=> !ADDRESS_STROBE_OE_O || state_r == ST_RESET) else $error("bus not floated"); // RL6
  grant_float_a: assert property (!BUS_GRANT_N_O |-> !ADDRESS_STROBE_OE_O
    && !DATA_STROBE_OE_O && !MUXED_ADDR_DATA_PORT_OE_O) else $error("pins driven in grant"); // RL13
  wait_exact_a: assert property (state_r == ST_T3A && $past(state_r) == ST_WAIT
    && !stall_cfg_r[STALL_EN_BIT] |-> wait_seen_r == wait_n) else $error("wait count wrong"); // RL22
  no_wait_a: assert property (state_r == ST_T2B && (!ext_r || (wait_n == 3'h0
    && !stall_act)) && chip_run |=> state_r == ST_T3A) else $error("unexpected wait"); // RL19
  reset_pins_a: assert property (state_r == ST_RESET && $past(state_r) == ST_RESET
    |-> !DATA_STROBE_N_O && !READ_NOT_WRITE_OE_O) else $error("reset pin state wrong"); // RL23
  read_release_a: assert property (state_r inside {ST_T2A, ST_T2B, ST_WAIT} && !req_r.write
    |-> !MUXED_ADDR_DATA_PORT_OE_O) else $error("port driven during read"); // RL16
  write_data_a: assert property (ext_r && req_r.write && state_r == ST_T2B
    |-> !DATA_STROBE_N_O && MUXED_ADDR_DATA_PORT_O == req_r.wdata) else $error("write data"); // RL8
  resume_two_a: assert property ($fell(state_r == ST_FLOAT) && chip_run
    |-> resume_seq or ##[0:2] state_r == ST_RESET) else $error("resume timing wrong"); // RL25

endmodule

// [verification/ext_mem_model.sv]
`timescale 1ns/10ps
module ext_mem_model (
  input wire logic clk_i,
  input wire logic as_n_i,
  input wire logic ds_n_i,
  input wire logic rw_i,
  input wire logic [7:0] high_i,
  input wire logic [7:0] bus_i,
  input wire logic [3:0] hold_clks_i,
  output logic [7:0] bus_o,
  output logic bus_oe_o,
  output logic hold_n_o,
  output logic [7:0] wr_data_o
);
  // --------------------
  // Far-side byte memory
  // --------------------
  logic [15:0] addr_r = 16'h0000;
  logic ds_q_r = 1'b1;
  logic [3:0] hold_r = 4'h0;
  // Address caught while the strobe is low, write data at the strobe trailing edge
  always @(posedge clk_i) begin
    ds_q_r <= ds_n_i;
    if (!as_n_i) addr_r <= {high_i, bus_i};
    if (ds_n_i && !ds_q_r && !rw_i) wr_data_o <= bus_i;
    if (ds_q_r && !ds_n_i) hold_r <= hold_clks_i;
    else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
  end
  // Drives only while the read strobe is low, so a late turn-around shows up
  assign bus_oe_o = !ds_n_i && rw_i && as_n_i;
  assign bus_o = addr_r[7:0] ^ addr_r[15:8] ^ 8'h5A;
  assign hold_n_o = (hold_r == 4'h0);
endmodule

// [verification/external_memory_bus_interface_bench.sv]
`timescale 1ns/10ps
module external_memory_bus_interface_bench;
  import ext_bus_pkg::*;
  // --------------------
  // Signals and instances
  // --------------------
  logic ref_clk = 1'b0, rst_n = 1'b0, chip_rst_n = 1'b0, bus_request_n_n = 1'b1, prev;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req_valid = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  mem_req_type req = '0;
  logic pready, pslverr, req_ready, done, as_n, as_oe, ds_n, ds_oe, rw_o, rw_oe, rw_pu;
  logic pd, pd_oe, mux_oe, high_oe, xlow_oe, m_oe, hold_n, grant_n, rws, moe;
  logic [1:0] pds;
  logic [7:0] rdata, mux_o, high_o, xlow_o, m_d, m_wr, last_bus = 8'h00;
  logic [15:0] his;
  logic [3:0] hold_clks = 4'h0;
  int n_mismatch = 0, check_count = 0, cyc = 0, lat, dsl, n;
  logic [15:0] ta [6] = '{16'h8123, 16'h9456, 16'h8234, 16'h0100, 16'h1000, 16'hA000};
  logic [0:5] twr = 6'b001001, tpg = 6'b010011;
  int tlat [6] = '{10, 12, 10, 7, 7, 12};
  int tdsl [6] = '{7, 9, 5, 0, 0, 7};
  // A released data line shows the inverse of its last value; strobes have board pull-ups
  wire logic [7:0] bus = mux_oe ? mux_o : (m_oe ? m_d : ~last_bus);
  wire logic as_lvl = as_oe ? as_n : 1'b1;
  wire logic ds_lvl = ds_oe ? ds_n : 1'b1;
  wire logic rw_lvl = rw_oe ? rw_o : 1'b1;
  ext_mem_if dut (
    .REF_CLK_I(ref_clk), .RST_N_I(rst_n), .CHIP_RESET_N_I(chip_rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .REQ_VALID_I(req_valid),
    .REQ_I(req), .REQ_READY_O(req_ready), .DONE_O(done), .RDATA_O(rdata),
    .ADDRESS_STROBE_N_O(as_n), .ADDRESS_STROBE_OE_O(as_oe), .DATA_STROBE_N_O(ds_n),
    .DATA_STROBE_OE_O(ds_oe), .READ_NOT_WRITE_I(rw_lvl), .READ_NOT_WRITE_O(rw_o),
    .READ_NOT_WRITE_OE_O(rw_oe), .READ_NOT_WRITE_PULLUP_O(rw_pu), .PROGRAM_DATA_SELECT_O(pd),
    .PROGRAM_DATA_SELECT_OE_O(pd_oe), .MUXED_ADDR_DATA_PORT_I(bus),
    .MUXED_ADDR_DATA_PORT_O(mux_o), .MUXED_ADDR_DATA_PORT_OE_O(mux_oe),
    .HIGH_ADDRESS_PORT_O(high_o), .HIGH_ADDRESS_PORT_OE_O(high_oe),
    .EXTRA_LOW_ADDRESS_PORT_O(xlow_o), .EXTRA_LOW_ADDRESS_PORT_OE_O(xlow_oe),
    .SLOW_MEMORY_HOLD_N_I(hold_n), .BUS_REQUEST_N_I(bus_request_n_n), .BUS_GRANT_N_O(grant_n));
  ext_mem_model mem (.clk_i(ref_clk), .as_n_i(as_lvl), .ds_n_i(ds_lvl), .rw_i(rw_lvl),
    .high_i(high_o), .bus_i(bus), .hold_clks_i(hold_clks), .bus_o(m_d), .bus_oe_o(m_oe),
    .hold_n_o(hold_n), .wr_data_o(m_wr));
  // --------------------
  // Clock, timeout and tasks
  // --------------------
  always #50 ref_clk = ~ref_clk;
  // Hang guard; the whole run needs well under 2000 cycles
  always @(posedge ref_clk) begin
    last_bus <= bus;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; an idle edge first keeps back-to-back calls glitch free
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1'b1, pready);
  endtask
  // One core request; counts clocks to done and strobe-low clocks on the way
  task automatic acc(input logic wr, input logic pg, input logic [15:0] a, input logic [7:0] wd);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{wr, pg, a, wd};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    req_valid <= 1'b0;
    lat = 0;
    dsl = 0;
    do begin
      @(posedge ref_clk);
      lat++;
      if (lat == 1) {rws, his, pds} = {rw_lvl, high_o, xlow_o, pd_oe, pd};
      if (lat == 4) moe = mux_oe;
      if (ds_n === 1'b0 && ds_oe === 1'b1) dsl++;
    end while (done !== 1'b1 && lat < 200);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk("reset pins", 4'b0110, {ds_n, ds_oe, rw_pu, rw_oe});
    prev = as_n;
    n = 0;
    repeat (64) begin
      @(posedge ref_clk);
      if (as_n !== prev) n++;
      prev = as_n;
    end
    chk("strobe toggles", 4, n);
    apb(1'b0, MODE_ADDR, 32'h0);
    chk("mode reset", 32'hE0, rd);
    apb(1'b0, WAIT_ADDR, 32'h0);
    chk("wait reset", 32'h7F, rd);
    apb(1'b0, STALL_ADDR, 32'h0);
    chk("stall reset", 32'h02, rd);
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped", 32'h8000_0000, {er, rd[30:0]});
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status in reset", 32'h40, rd);
    repeat (SYNC_MIN_PERIODS) @(posedge ref_clk);
    chip_rst_n <= 1'b1;
    apb(1'b1, PINCFG_ADDR, 32'h1);
    apb(1'b1, WAIT_ADDR, 32'h2B);
    for (int i = 0; i < 6; i++) begin
      acc(twr[i], tpg[i], ta[i], ta[i][7:0] ^ 8'hF0);
      chk("latency", tlat[i], lat);
      chk("strobe low clocks", tdsl[i], dsl);
      chk("read not write", !twr[i], rws);
      chk("program data select", {1'b1, tpg[i]}, pds);
      if (tdsl[i] != 0) chk("address", ta[i], his);
      if (tdsl[i] != 0) chk("muxed drive", twr[i], moe);
      if (twr[i]) chk("write data", ta[i][7:0] ^ 8'hF0, m_wr);
      else chk("read data", tdsl[i] == 0 ? 8'h00 : ta[i][7:0] ^ ta[i][15:8] ^ 8'h5A, rdata);
    end
    // Four counted waits give a stall the time to cross the synchroniser
    apb(1'b1, WAIT_ADDR, 32'h04);
    hold_clks <= 4'h6;
    acc(1'b0, 1'b0, 16'h8000, 8'h00);
    chk("stall ignored", 11, lat);
    apb(1'b1, STALL_ADDR, 32'h03);
    acc(1'b0, 1'b0, 16'h8000, 8'h00);
    chk("stall stretch", 1'b1, lat > 11 && lat < 20);
    hold_clks <= 4'h0;
    apb(1'b1, MODE_ADDR, 32'hE1);
    repeat (3) @(posedge ref_clk);
    chk("float", 3'b000, {as_oe, ds_oe, rw_oe});
    acc(1'b0, 1'b0, 16'h0100, 8'h00);
    chk("on-chip while floated", 7, lat);
    bus_request_n_n <= 1'b0;
    apb(1'b1, MODE_ADDR, 32'hE0);
    acc(1'b0, 1'b0, 16'h8000, 8'h00);
    repeat (10) @(posedge ref_clk);
    chk("grant while disabled", 1'b1, grant_n);
    apb(1'b1, MODE_ADDR, 32'hE2);
    acc(1'b0, 1'b0, 16'h8000, 8'h00);
    n = 0;
    while (grant_n !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    chk("released bus", 7'h00, {grant_n, as_oe, ds_oe, rw_oe, mux_oe, high_oe, xlow_oe});
    bus_request_n_n <= 1'b1;
    n = 0;
    while (as_oe !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    chk("resume clocks", 2, n);
    chk("grant returned", 1'b1, grant_n);
    tally_and_finish();
  end
endmodule
